// ---- include/bsp_consts.svh ----
// Constants of the boot self-programming section controller
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define BSP_OFF_CTRL       4'h0
`define BSP_OFF_IRQ_STAT   4'h1
`define BSP_OFF_IRQ_CLR    4'h2
`define BSP_OFF_IRQ_EN     4'h3
`define BSP_OFF_BOOT_PAGE  4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BSP_CTRL_RWW_RE    4
`define BSP_CTRL_RWW_BUSY  6
`define BSP_CTRL_STALL     7
`define BSP_CTRL_STATE_MSB 2
`define BSP_LOCK_WR        0
`define BSP_EV_DONE        0
`define BSP_EV_IGNORED     1
`define BSP_EV_LOCKED      2
`define BSP_NUM_EV         3

// ----------------------------------------------------------------
// Reset values and fixed addresses
// ----------------------------------------------------------------
`define BSP_RST_BYTE       8'h00
`define BSP_APP_RESET_ADDR 16'h0000
`define BSP_FUSE_UNPROG    1'b1

`endif

// ---- include/bsp_pkg.sv ----
// Types of the boot self-programming section controller
package bsp_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        BSP_ST_IDLE = 3'b001,
        BSP_ST_RWW  = 3'b010,
        BSP_ST_NO_READ_WHILE_WRITE_AREA = 3'b100
    } bsp_state_t;

    // Store-program commands issued by the CPU
    typedef enum logic [1:0] {
        BSP_CMD_LOAD  = 2'h0,
        BSP_CMD_ERASE = 2'h1,
        BSP_CMD_WRITE = 2'h2
    } bsp_cmd_t;

endpackage

// ---- rtl/bsp_section_map.sv ----
// Address to section decode for two addresses at once
`timescale 1ns/1ps
module bsp_section_map #(
    parameter int AW         = 16,
    parameter int NO_READ_WHILE_WRITE_AREA_START = 16'h0c00,
    parameter int BOOT_SZ0   = 16'h0400,
    parameter int BOOT_SZ1   = 16'h0200,
    parameter int BOOT_SZ2   = 16'h0100,
    parameter int BOOT_SZ3   = 16'h0080,
    parameter int FLASH_WORDS = 16'h1000
) (
    input  wire logic [1:0]    boot_size_fuses,
    input  wire logic [AW-1:0] addr_a,
    input  wire logic [AW-1:0] addr_b,
    output logic [AW-1:0]      boot_start,
    output logic               a_in_boot,
    output logic               b_in_boot,
    output logic               b_in_rww
);
    // ------------------------------------------------------------
    // Boundaries
    // ------------------------------------------------------------
    logic [AW-1:0] raw_start;
    logic [AW-1:0] no_read_while_write_area_lim;

    // Fuse selects the boot area size; largest size at fuses 00
    assign raw_start = (boot_size_fuses == 2'h0) ? AW'(FLASH_WORDS - BOOT_SZ0) :
                       (boot_size_fuses == 2'h1) ? AW'(FLASH_WORDS - BOOT_SZ1) :
                       (boot_size_fuses == 2'h2) ? AW'(FLASH_WORDS - BOOT_SZ2) :
                                                   AW'(FLASH_WORDS - BOOT_SZ3);
    assign no_read_while_write_area_lim  = AW'(NO_READ_WHILE_WRITE_AREA_START);
    // A boot area never reaches below the fixed boundary, whatever the fuses
    assign boot_start = (raw_start < no_read_while_write_area_lim) ? no_read_while_write_area_lim : raw_start;

    function automatic logic in_boot(input logic [AW-1:0] a, input logic [AW-1:0] s);
        in_boot = (a >= s);
    endfunction

    // Two independent splits of the same array
    assign a_in_boot = in_boot(addr_a, boot_start);
    assign b_in_boot = in_boot(addr_b, boot_start);
    assign b_in_rww  = (addr_b < no_read_while_write_area_lim);
endmodule // bsp_section_map

// ---- rtl/bsp_irq.sv ----
// Sticky event status, enable and clear, one level interrupt
`timescale 1ns/1ps
module bsp_irq #(
    parameter int NEV = 3
) (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic           ce,
    input  wire logic [NEV-1:0] ev,
    input  wire logic [NEV-1:0] clr,
    input  wire logic           en_wr,
    input  wire logic [NEV-1:0] en_wdata,
    output logic [NEV-1:0]      status_reg,
    output logic [NEV-1:0]      enable_reg,
    output logic                irq_reg
);
    // ------------------------------------------------------------
    // Sticky bits: a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NEV; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    status_reg[i] <= 1'b0;
                end else if (ce) begin
                    status_reg[i] <= ev[i] | (status_reg[i] & ~clr[i]);
                end
            end
        end
    endgenerate

    // Enable register and registered interrupt level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_reg <= '0;
            irq_reg    <= 1'b0;
        end else if (ce) begin
            if (en_wr) begin
                enable_reg <= en_wdata;
            end
            irq_reg <= |(status_reg & enable_reg);
        end
    end
endmodule // bsp_irq

// ---- rtl/bsp_top.sv ----
// Section access control for Flash self-programming
`timescale 1ns/1ps
`include "bsp_consts.svh"
module bsp_top #(
    parameter int AW          = 16,
    parameter int PAGE_BITS   = 5,
    parameter int FLASH_WORDS = 16'h1000,
    parameter int NO_READ_WHILE_WRITE_AREA_START  = 16'h0c00,
    parameter int BOOT_SZ0    = 16'h0400,
    parameter int BOOT_SZ1    = 16'h0200,
    parameter int BOOT_SZ2    = 16'h0100,
    parameter int BOOT_SZ3    = 16'h0080
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Fuses and lock bits
    input  wire logic [1:0]    boot_size_fuses,
    input  wire logic          boot_reset_vector_fuse,
    input  wire logic [1:0]    app_lock_bits,
    input  wire logic [1:0]    boot_lock_bits,
    // CPU side
    input  wire logic [AW-1:0] pc_addr,
    input  wire logic          spm_req,
    input  wire logic [1:0]    spm_cmd,
    input  wire logic [AW-1:0] spm_addr,
    output logic               cpu_stall_reg,
    output logic               rww_area_busy_flag_reg,
    output logic [AW-1:0]      reset_vector_reg,
    // Flash array side
    output logic               flash_start_reg,
    output logic [1:0]         flash_cmd_reg,
    output logic [AW-1:0]      flash_addr_reg,
    input  wire logic          flash_done,
    // Register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata_reg,
    output logic               irq_reg
);
    // ------------------------------------------------------------
    // Section decode
    // ------------------------------------------------------------
    logic [AW-1:0] boot_start;
    logic          pc_in_boot;
    logic          tgt_in_boot;
    logic          tgt_in_rww;

    bsp_section_map #(
        .AW          (AW),
        .NO_READ_WHILE_WRITE_AREA_START  (NO_READ_WHILE_WRITE_AREA_START),
        .BOOT_SZ0    (BOOT_SZ0),
        .BOOT_SZ1    (BOOT_SZ1),
        .BOOT_SZ2    (BOOT_SZ2),
        .BOOT_SZ3    (BOOT_SZ3),
        .FLASH_WORDS (FLASH_WORDS)
    ) u_map (
        .boot_size_fuses (boot_size_fuses),
        .addr_a          (pc_addr),
        .addr_b          (spm_addr),
        .boot_start      (boot_start),
        .a_in_boot       (pc_in_boot),
        .b_in_boot       (tgt_in_boot),
        .b_in_rww        (tgt_in_rww)
    );

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    bsp_pkg::bsp_state_t state_reg;
    bsp_pkg::bsp_state_t state_next;
    logic          is_idle;
    logic          is_prog;
    logic          is_load;
    logic          lock_hit;
    logic          req_ok;
    logic          go_prog;
    logic          go_load;
    logic          ev_ignored;
    logic          ev_locked;
    logic          ev_done;
    logic [AW-1:0] page_addr;

    assign is_idle  = (state_reg == bsp_pkg::BSP_ST_IDLE);
    assign is_prog  = (spm_cmd == bsp_pkg::BSP_CMD_ERASE) |
                      (spm_cmd == bsp_pkg::BSP_CMD_WRITE);
    assign is_load  = (spm_cmd == bsp_pkg::BSP_CMD_LOAD);
    // Low bit of each pair programmed (0) forbids writes to that area
    assign lock_hit = is_prog & (tgt_in_boot ? ~boot_lock_bits[`BSP_LOCK_WR]
                                             : ~app_lock_bits[`BSP_LOCK_WR]);
    // Only code fetched from the boot area may start anything
    assign req_ok   = spm_req & is_idle & pc_in_boot;
    // Target may be anywhere, boot area included
    assign go_prog  = req_ok & is_prog & ~lock_hit;
    assign go_load  = req_ok & is_load;
    assign ev_ignored = spm_req & ~pc_in_boot;
    assign ev_locked  = spm_req & pc_in_boot & (lock_hit | ~is_idle);
    assign ev_done    = ~is_idle & flash_done;
    // Erase and write act on whole pages; loads keep the word address
    assign page_addr = {spm_addr[AW-1:PAGE_BITS], {PAGE_BITS{1'b0}}};

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic         wr_ctrl;
    logic         wr_clr;
    logic         wr_en;
    logic         rww_re;
    logic [7:0]   rd_mux;
    logic [`BSP_NUM_EV-1:0] irq_status;
    logic [`BSP_NUM_EV-1:0] irq_enable;
    logic [`BSP_NUM_EV-1:0] irq_ev;

    assign wr_ctrl = reg_wr & (reg_addr == `BSP_OFF_CTRL);
    assign wr_clr  = reg_wr & (reg_addr == `BSP_OFF_IRQ_CLR);
    assign wr_en   = reg_wr & (reg_addr == `BSP_OFF_IRQ_EN);
    // Read enable only takes effect once the operation has finished
    assign rww_re  = wr_ctrl & reg_wdata[`BSP_CTRL_RWW_RE] & is_idle;

    always_comb begin
        rd_mux = `BSP_RST_BYTE;
        if (reg_addr == `BSP_OFF_CTRL) begin
            rd_mux[`BSP_CTRL_RWW_BUSY] = rww_area_busy_flag_reg;
            rd_mux[`BSP_CTRL_STALL]    = cpu_stall_reg;
            rd_mux[`BSP_CTRL_STATE_MSB:0] = state_reg;
        end else if (reg_addr == `BSP_OFF_IRQ_STAT) begin
            rd_mux[`BSP_NUM_EV-1:0] = irq_status;
        end else if (reg_addr == `BSP_OFF_IRQ_EN) begin
            rd_mux[`BSP_NUM_EV-1:0] = irq_enable;
        end else if (reg_addr == `BSP_OFF_BOOT_PAGE) begin
            rd_mux = 8'(boot_start >> PAGE_BITS);
        end
    end

    assign irq_ev = {ev_locked, ev_ignored, ev_done};

    bsp_irq #(
        .NEV (`BSP_NUM_EV)
    ) u_irq (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .ce         (ce),
        .ev         (irq_ev),
        .clr        (wr_clr ? reg_wdata[`BSP_NUM_EV-1:0] : {`BSP_NUM_EV{1'b0}}),
        .en_wr      (wr_en),
        .en_wdata   (reg_wdata[`BSP_NUM_EV-1:0]),
        .status_reg (irq_status),
        .enable_reg (irq_enable),
        .irq_reg    (irq_reg)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // READ_WHILE_WRITE_AREA targets let the CPU run; NO_READ_WHILE_WRITE_AREA targets hold it for the operation
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bsp_pkg::BSP_ST_IDLE: begin
                if (go_prog) begin
                    state_next = tgt_in_rww ? bsp_pkg::BSP_ST_RWW
                                            : bsp_pkg::BSP_ST_NO_READ_WHILE_WRITE_AREA;
                end
            end
            bsp_pkg::BSP_ST_RWW: begin
                if (flash_done) begin
                    state_next = bsp_pkg::BSP_ST_IDLE;
                end
            end
            bsp_pkg::BSP_ST_NO_READ_WHILE_WRITE_AREA: begin
                if (flash_done) begin
                    state_next = bsp_pkg::BSP_ST_IDLE;
                end
            end
            default: state_next = bsp_pkg::BSP_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg     <= bsp_pkg::BSP_ST_IDLE;
            cpu_stall_reg <= 1'b0;
        end else if (ce) begin
            state_reg     <= state_next;
            cpu_stall_reg <= (state_next == bsp_pkg::BSP_ST_NO_READ_WHILE_WRITE_AREA);
        end
    end

    // Busy flag: start of an READ_WHILE_WRITE_AREA operation wins over any clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rww_area_busy_flag_reg <= 1'b0;
        end else if (ce) begin
            if (go_prog & tgt_in_rww) begin
                rww_area_busy_flag_reg <= 1'b1;
            end else if (go_load | rww_re) begin
                rww_area_busy_flag_reg <= 1'b0;
            end
        end
    end

    // Command to the Flash array, one-cycle start pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flash_start_reg <= 1'b0;
            flash_cmd_reg   <= bsp_pkg::BSP_CMD_LOAD;
            flash_addr_reg  <= '0;
        end else if (ce) begin
            flash_start_reg <= go_prog | go_load;
            if (go_prog | go_load) begin
                flash_cmd_reg  <= spm_cmd;
                flash_addr_reg <= go_prog ? page_addr : spm_addr;
            end
        end
    end

    // Reset address follows the boot reset fuse; caught while reset holds
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reset_vector_reg <= (boot_reset_vector_fuse == `BSP_FUSE_UNPROG) ?
                                AW'(`BSP_APP_RESET_ADDR) : boot_start;
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_reg <= `BSP_RST_BYTE;
        end else if (ce) begin
            reg_rdata_reg <= reg_rd ? rd_mux : `BSP_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    app_spm_ignored_a: assert property (
        ce && spm_req && !pc_in_boot |=> !flash_start_reg)
        else $error("store-program from application area started flash");
    busy_set_a: assert property (
        ce && go_prog && tgt_in_rww |=> rww_area_busy_flag_reg && !cpu_stall_reg)
        else $error("busy flag not set on rww operation");
    no_read_while_write_area_stall_a: assert property (
        ce && go_prog && !tgt_in_rww |=> cpu_stall_reg && state_reg == bsp_pkg::BSP_ST_NO_READ_WHILE_WRITE_AREA)
        else $error("cpu not stalled for no_read_while_write_area operation");
    rww_nostall_a: assert property (
        state_reg == bsp_pkg::BSP_ST_RWW |-> !cpu_stall_reg)
        else $error("cpu stalled during rww operation");
    rww_blocked_a: assert property (
        state_reg == bsp_pkg::BSP_ST_RWW |-> rww_area_busy_flag_reg)
        else $error("rww area readable while programmed");
    load_clears_a: assert property (
        ce && go_load |=> !rww_area_busy_flag_reg && flash_start_reg &&
        flash_cmd_reg == bsp_pkg::BSP_CMD_LOAD)
        else $error("page load did not clear busy flag");
    // A boot target must always take the stalling path, whatever the fuses
    boot_in_no_read_while_write_area_a: assert property (
        ce && go_prog && tgt_in_boot |=> cpu_stall_reg)
        else $error("boot area reaches into rww area");
    page_align_a: assert property (
        flash_start_reg && flash_cmd_reg != bsp_pkg::BSP_CMD_LOAD
        |-> flash_addr_reg[PAGE_BITS-1:0] == '0)
        else $error("erase or write not page aligned");
    stall_release_a: assert property (
        ce && state_reg == bsp_pkg::BSP_ST_NO_READ_WHILE_WRITE_AREA && flash_done |=> !cpu_stall_reg)
        else $error("stall held after operation end");
    lock_block_a: assert property (
        ce && spm_req && lock_hit |=> !flash_start_reg)
        else $error("locked area was programmed");
    // Refused requests must still leave a trace in the status bits
    ignored_flag_a: assert property (
        ce && spm_req && !pc_in_boot |=> irq_status[`BSP_EV_IGNORED])
        else $error("ignored request not flagged");
    lock_flag_a: assert property (
        ce && spm_req && pc_in_boot && lock_hit |=> irq_status[`BSP_EV_LOCKED])
        else $error("locked request not flagged");
    prog_start_a: assert property (
        ce && go_prog |=> flash_start_reg && flash_addr_reg == $past(page_addr))
        else $error("accepted operation not sent to flash");
    // Busy may only drop through a load or a read enable write
    busy_hold_a: assert property (
        rww_area_busy_flag_reg && !(ce && (go_load || rww_re)) |=> rww_area_busy_flag_reg)
        else $error("busy flag dropped without a clear");
    rww_re_clears_a: assert property (
        ce && rww_re && !(go_prog && tgt_in_rww) |=> !rww_area_busy_flag_reg)
        else $error("read enable did not clear busy flag");
endmodule // bsp_top

// ---- testbench/bsp_flash_model.sv ----
// Behavioural Flash array that answers erase and write starts
`timescale 1ns/1ps
module bsp_flash_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       flash_start,
    input  wire logic [1:0] flash_cmd,
    input  wire logic [7:0] delay,
    output logic            flash_done
);
    logic [7:0] cnt_reg;
    logic       run_reg;

    // ------------------------------------------------------------
    // Programming timer
    // ------------------------------------------------------------
    // The delay comes from the bench, so it can answer promptly or slowly
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg    <= 8'h00;
            run_reg    <= 1'b0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= run_reg && (cnt_reg == 8'h00);
            // A page load only fills the buffer, so no done pulse follows it
            if (flash_start && flash_cmd != bsp_pkg::BSP_CMD_LOAD) begin
                cnt_reg <= delay;
                run_reg <= 1'b1;
            end else if (run_reg && cnt_reg == 8'h00) begin
                run_reg <= 1'b0;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule // bsp_flash_model

// ---- testbench/bsp_top_tb.sv ----
// Self-checking bench for the self-programming section controller
`timescale 1ns/1ps
module bsp_top_tb;
    logic        mclk, rst_n, ce, fuse_rst, flash_done;
    logic [1:0]  fuse_sz, app_lock, boot_lock, spm_cmd, flash_cmd;
    logic [15:0] pc_addr, spm_addr, rst_vec, flash_addr;
    logic        spm_req, stall, busy, flash_start, reg_wr, reg_rd, irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, rdata, fl_delay;
    int          err_count, total_checks;
    logic [15:0] boot_tab [4] = '{16'h0c00, 16'h0e00, 16'h0f00, 16'h0f80};

    bsp_top u_dut (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .boot_size_fuses(fuse_sz), .boot_reset_vector_fuse(fuse_rst),
        .app_lock_bits(app_lock), .boot_lock_bits(boot_lock),
        .pc_addr(pc_addr), .spm_req(spm_req), .spm_cmd(spm_cmd), .spm_addr(spm_addr),
        .cpu_stall_reg(stall), .rww_area_busy_flag_reg(busy), .reset_vector_reg(rst_vec),
        .flash_start_reg(flash_start), .flash_cmd_reg(flash_cmd),
        .flash_addr_reg(flash_addr), .flash_done(flash_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_reg(rdata), .irq_reg(irq)
    );

    bsp_flash_model u_flash (
        .mclk(mclk), .rst_n(rst_n), .flash_start(flash_start),
        .flash_cmd(flash_cmd), .delay(fl_delay), .flash_done(flash_done)
    );

    // ------------------------------------------------------------
    // Clock, time-zero values and watchdog
    // ------------------------------------------------------------
    // Every input gets a value before the first edge
    initial begin
        mclk = 1'b0; rst_n = 1'b0; ce = 1'b1; fuse_rst = 1'b1; fuse_sz = 2'h0;
        app_lock = 2'h3; boot_lock = 2'h3; pc_addr = 16'h0000; spm_addr = 16'h0000;
        spm_req = 1'b0; spm_cmd = 2'h0; reg_addr = 4'h0; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; fl_delay = 8'h03;
        forever #5 mclk = ~mclk;
    end

    // The whole run needs a few thousand cycles at most
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic store_program_instruction(input logic [15:0] pc, input bsp_pkg::bsp_cmd_t c,
                       input logic [15:0] a);
        @(posedge mclk);
        spm_req <= 1'b1; pc_addr <= pc; spm_cmd <= c; spm_addr <= a;
        @(posedge mclk);
        spm_req <= 1'b0;
        #1;
    endtask

    // Stall must hold its value until the edge after done
    task automatic wait_done(input logic stall_exp);
        repeat (300) begin
            if (flash_done === 1'b1) break;
            @(posedge mclk);
            #1 chk(stall, stall_exp);
        end
        chk(flash_done, 1'b1);
        @(posedge mclk);
        #1 chk(stall, 1'b0);
    endtask

    task automatic do_reset(input logic f, input logic [1:0] s);
        @(posedge mclk);
        rst_n <= 1'b0; fuse_rst <= f; fuse_sz <= s;
        @(posedge mclk);
        @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk({stall, busy, flash_start, irq}, 4'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sizes();
        for (int s = 0; s < 4; s++) begin
            do_reset(1'b0, s[1:0]);
            chk(rst_vec, boot_tab[s]);
            reg_read(4'h4, boot_tab[s][12:5]);
        end
        do_reset(1'b1, 2'h3);
        chk(rst_vec, 16'h0000);
        $display("test sizes done");
    endtask

    task automatic t_ignore_irq();
        store_program_instruction(16'h0f7f, bsp_pkg::BSP_CMD_ERASE, 16'h0f80);
        chk(flash_start, 1'b0);
        reg_read(4'h1, 8'h02);
        reg_write(4'h3, 8'h02);
        @(posedge mclk);
        #1 chk(irq, 1'b1);
        reg_write(4'h3, 8'h00);
        @(posedge mclk);
        #1 chk(irq, 1'b0);
        reg_write(4'h3, 8'h02);
        reg_write(4'h2, 8'h02);
        @(posedge mclk);
        #1 chk(irq, 1'b0);
        reg_read(4'h1, 8'h00);
        reg_read(4'h2, 8'h00);
        reg_write(4'hf, 8'hff);
        reg_read(4'hf, 8'h00);
        reg_read(4'h3, 8'h02);
        $display("test ignore_irq done");
    endtask

    task automatic t_no_read_while_write_area();
        fl_delay <= 8'h14;
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0f95);
        chk(flash_start, 1'b1);
        chk(flash_addr, 16'h0f80);
        chk({stall, busy}, 2'b10);
        reg_read(4'h0, 8'h84);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_WRITE, 16'h0fa0);
        chk(flash_start, 1'b0);
        wait_done(1'b1);
        reg_read(4'h1, 8'h05);
        reg_write(4'h2, 8'h07);
        $display("test no_read_while_write_area done");
    endtask

    task automatic t_rww();
        fl_delay <= 8'h03;
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_WRITE, 16'h0123);
        chk(flash_start, 1'b1);
        chk({14'h0, flash_cmd}, {14'h0, 2'h2});
        chk(flash_addr, 16'h0120);
        chk({stall, busy}, 2'b01);
        wait_done(1'b0);
        chk(busy, 1'b1);
        reg_read(4'h0, 8'h41);
        reg_write(4'h0, 8'h10);
        chk(busy, 1'b0);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0000);
        chk(busy, 1'b1);
        wait_done(1'b0);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_LOAD, 16'h0005);
        chk(busy, 1'b0);
        $display("test rww done");
    endtask

    task automatic t_locks();
        reg_write(4'h2, 8'h07);
        app_lock <= 2'h2;
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0100);
        chk(flash_start, 1'b0);
        reg_read(4'h1, 8'h04);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0fa0);
        chk(flash_start, 1'b1);
        wait_done(1'b1);
        app_lock <= 2'h3;
        boot_lock <= 2'h2;
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0fa0);
        chk(flash_start, 1'b0);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_ERASE, 16'h0040);
        chk(flash_start, 1'b1);
        wait_done(1'b0);
        reg_write(4'h0, 8'h10);
        chk(busy, 1'b0);
        $display("test locks done");
    endtask

    // With the clock enable low nothing may be taken or flagged
    task automatic t_freeze();
        reg_write(4'h2, 8'h07);
        ce <= 1'b0;
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_WRITE, 16'h0200);
        chk({flash_start, busy, stall}, 3'h0);
        ce <= 1'b1;
        reg_read(4'h1, 8'h00);
        store_program_instruction(16'h0f80, bsp_pkg::BSP_CMD_WRITE, 16'h0200);
        chk({flash_start, busy, stall}, 3'h6);
        wait_done(1'b0);
        $display("test freeze done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset is held two cycles before the first scenario
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_sizes();
        t_ignore_irq();
        t_no_read_while_write_area();
        t_rww();
        t_locks();
        t_freeze();
        wrap_up();
    end
endmodule // bsp_top_tb
